/* core/pcc_top.sv */
// pll clock select control: registers, clock handover, lock flag, crystal loss check
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
module pcc_top
  import pcc_pkg::*;
#(
  parameter int unsigned ADDR_W         = 12,
  parameter int unsigned HANDOVER_EDGES = PCC_HANDOVER_EDGES
)
(
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // axi4-lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // axi4-lite read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // system integration side
  input  wire logic              osc_enable_in,
  output logic                   xtal_clock_out,
  output logic                   base_clock_out,
  output logic                   pll_irq,
  // analog loop side
  input  wire logic              xtal_clock_in,
  input  wire logic              vco_clock_in,
  input  wire logic              lock_in,
  input  wire logic              acq_in,
  output logic                   pll_enable_out,
  output logic                   auto_bw_out,
  output logic                   manual_tracking_out,
  output logic [3:0]             multiplier_out,
  output logic [3:0]             vco_range_out
);

  if (ADDR_W < 10 || ADDR_W > 32) begin : g_chk_addr
    $error("ADDR_W must be 10 to 32");
  end
  if (HANDOVER_EDGES < 1 || HANDOVER_EDGES > 7) begin : g_chk_hand
    $error("HANDOVER_EDGES must be 1 to 7");
  end

  localparam logic [2:0] HAND_CNT = 3'(HANDOVER_EDGES);
  localparam int unsigned NSYNC = 4;
  localparam int unsigned SX = 0;
  localparam int unsigned SV = 1;
  localparam int unsigned SL = 2;
  localparam int unsigned SA = 3;

  function automatic pcc_sel_t decode(input logic [ADDR_W-1:0] addr);
    pcc_sel_t s;
    s = PCC_SEL_NONE;
    if (addr[1:0] == 2'b00 && (addr >> 10) == '0)
    begin
      if (addr[9:2] == PCC_CTRL_IDX)
        s = PCC_SEL_CTRL;
      else if (addr[9:2] == PCC_BW_IDX)
        s = PCC_SEL_BW;
      else if (addr[9:2] == PCC_PROG_IDX)
        s = PCC_SEL_PROG;
    end
    return s;
  endfunction

  // registers
  logic        ie_ff, flag_ff, on_ff, bcs_ff;
  logic        auto_ff, trk_man_ff, xld_ff;
  logic [7:0]  prog_ff;
  // bus state
  logic              awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic [1:0]        bresp_ff, rresp_ff;
  logic [31:0]       rdata_ff;
  logic              aw_got_ff, w_got_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [7:0]        wdata_ff;
  logic              wlane_ff;
  // synchronisers
  logic [NSYNC-1:0] sync1_ff, sync2_ff, sync3_ff;
  // clock path
  pcc_sw_t     sw_ff;
  logic        src_ff;
  logic [2:0]  xcnt_ff, vcnt_ff;
  logic        base_ff, xclk_ff, irq_ff;
  // loss window
  logic        win_ff, xseen_ff;
  logic [5:0]  win_cnt_ff;
  // outputs of the loop side
  logic        pll_en_ff;

  logic        x_rise, v_rise, lock_s, acq_s, lock_chg;
  logic        wr_do, rd_take;
  pcc_sel_t    wsel, rsel;
  logic        range_zero;
  logic [3:0]  mul_eff;
  logic [5:0]  win_len;
  logic [7:0]  ctrl_rd, bw_rd;

  // two-flop synchronisers plus an edge stage
  for (genvar i = 0; i < NSYNC; i++) begin : g_sync
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        sync1_ff[i] <= 1'b0;
        sync2_ff[i] <= 1'b0;
        sync3_ff[i] <= 1'b0;
      end
      else
      begin
        sync1_ff[i] <= (i == SX) ? xtal_clock_in :
                       (i == SV) ? vco_clock_in  :
                       (i == SL) ? lock_in : acq_in;
        sync2_ff[i] <= sync1_ff[i];          // RULE24
        sync3_ff[i] <= sync2_ff[i];
      end
    end
  end

  assign x_rise   = sync2_ff[SX] & ~sync3_ff[SX];
  assign v_rise   = sync2_ff[SV] & ~sync3_ff[SV];
  assign lock_s   = sync2_ff[SL];
  assign acq_s    = sync2_ff[SA];
  assign lock_chg = sync2_ff[SL] ^ sync3_ff[SL];

  assign wr_do      = aw_got_ff & w_got_ff & ~bvalid_ff;
  assign rd_take    = s_axi_arvalid & arready_ff;
  assign wsel       = decode(awaddr_ff);
  assign rsel       = decode(s_axi_araddr);
  assign range_zero = (prog_ff[3:0] == 4'h0);
  assign mul_eff    = (prog_ff[7:4] == 4'h0) ? 4'h1 : prog_ff[7:4];
  assign win_len    = 6'(PCC_LOSS_MULT) * {2'b00, mul_eff};

  // read views
  always_comb
  begin
    ctrl_rd = {ie_ff & auto_ff,                // RULE4
               flag_ff & auto_ff,              // RULE6
               on_ff, bcs_ff, PCC_CTRL_UNIMP}; // RULE2
    bw_rd   = {auto_ff,
               lock_s & auto_ff,               // RULE16
               auto_ff ? acq_s : trk_man_ff,   // RULE17
               xld_ff & bcs_ff,                // RULE22
               4'h0};                          // RULE15
  end

  // write address and data channels, taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_ff <= 1'b1;
      wready_ff  <= 1'b1;
      aw_got_ff  <= 1'b0;
      w_got_ff   <= 1'b0;
      awaddr_ff  <= '0;
      wdata_ff   <= 8'h00;
      wlane_ff   <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= PCC_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && awready_ff)
      begin
        awaddr_ff  <= s_axi_awaddr;
        aw_got_ff  <= 1'b1;
        awready_ff <= 1'b0;
      end
      if (s_axi_wvalid && wready_ff)
      begin
        wdata_ff  <= s_axi_wdata[7:0];
        wlane_ff  <= s_axi_wstrb[0];
        w_got_ff  <= 1'b1;
        wready_ff <= 1'b0;
      end
      if (wr_do)
      begin
        aw_got_ff <= 1'b0;
        w_got_ff  <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff  <= (wsel == PCC_SEL_NONE) ? PCC_RESP_SLVERR : PCC_RESP_OKAY;
      end
      else if (bvalid_ff && s_axi_bready)
      begin
        bvalid_ff  <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff  <= 1'b1;
      end
    end
  end

  // read channel, one cycle answer
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= PCC_RESP_OKAY;
    end
    else if (rd_take)
    begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b1;
      rresp_ff   <= (rsel == PCC_SEL_NONE) ? PCC_RESP_SLVERR : PCC_RESP_OKAY;
      unique case (rsel)
        PCC_SEL_CTRL: rdata_ff <= {24'h000000, ctrl_rd};
        PCC_SEL_BW:   rdata_ff <= {24'h000000, bw_rd};
        PCC_SEL_PROG: rdata_ff <= {24'h000000, prog_ff};
        PCC_SEL_NONE: rdata_ff <= 32'h0000_0000;
      endcase
    end
    else if (rvalid_ff && s_axi_rready)
    begin
      rvalid_ff  <= 1'b0;
      arready_ff <= 1'b1;
    end
  end

  // control register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ie_ff  <= PCC_CTRL_RESET[PCC_CTRL_IE_BIT];   // RULE3
      on_ff  <= PCC_CTRL_RESET[PCC_CTRL_ON_BIT];   // RULE3
      bcs_ff <= PCC_CTRL_RESET[PCC_CTRL_SEL_BIT];  // RULE3
    end
    else
    begin
      if (wr_do && wlane_ff && wsel == PCC_SEL_CTRL)
      begin
        if (auto_ff)
          ie_ff <= wdata_ff[PCC_CTRL_IE_BIT];                  // RULE4
        on_ff  <= wdata_ff[PCC_CTRL_ON_BIT] | bcs_ff;          // RULE9
        // select needs pll on both before and after this write
        bcs_ff <= wdata_ff[PCC_CTRL_SEL_BIT] & on_ff & ~range_zero
                  & (wdata_ff[PCC_CTRL_ON_BIT] | bcs_ff)
                  & osc_enable_in;                             // RULE10 RULE11
      end
      else if (!on_ff || range_zero || !osc_enable_in)
        bcs_ff <= 1'b0;                                        // RULE10 RULE13
      if (!auto_ff)
        ie_ff <= 1'b0;                                         // RULE4
    end
  end

  // interrupt flag: set wins over read clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      flag_ff <= PCC_CTRL_RESET[PCC_CTRL_FLAG_BIT];            // RULE3
    else if (auto_ff && osc_enable_in && lock_chg)
      flag_ff <= 1'b1;                                         // RULE5
    else if ((rd_take && rsel == PCC_SEL_CTRL) || !auto_ff)
      flag_ff <= 1'b0;                                         // RULE7
  end

  // bandwidth register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      auto_ff    <= PCC_BW_RESET[PCC_BW_AUTO_BIT];             // RULE15
      trk_man_ff <= PCC_BW_RESET[PCC_BW_TRK_BIT];
    end
    else if (wr_do && wlane_ff && wsel == PCC_SEL_BW)
    begin
      auto_ff <= wdata_ff[PCC_BW_AUTO_BIT];
      if (!auto_ff)
        trk_man_ff <= wdata_ff[PCC_BW_TRK_BIT];                // RULE17 RULE18
    end
  end

  // programming register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      prog_ff <= PCC_PROG_RESET;
    else if (wr_do && wlane_ff && wsel == PCC_SEL_PROG && !on_ff)
      prog_ff <= wdata_ff;                                     // RULE14
  end

  // crystal loss check
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      xld_ff     <= PCC_BW_RESET[PCC_BW_XLD_BIT];
      win_ff     <= 1'b0;
      xseen_ff   <= 1'b0;
      win_cnt_ff <= 6'd0;
    end
    else if (!bcs_ff || !osc_enable_in)
    begin
      xld_ff   <= 1'b0;                                        // RULE22
      win_ff   <= 1'b0;
      xseen_ff <= 1'b0;
    end
    else if (wr_do && wlane_ff && wsel == PCC_SEL_BW && wdata_ff[PCC_BW_XLD_BIT])
    begin
      xld_ff     <= 1'b1;                                      // RULE20
      win_ff     <= 1'b1;
      xseen_ff   <= 1'b0;
      win_cnt_ff <= win_len;
    end
    else if (win_ff)
    begin
      if (x_rise)
        xseen_ff <= 1'b1;
      if (v_rise)
        win_cnt_ff <= win_cnt_ff - 6'd1;
      if (v_rise && win_cnt_ff == 6'd1)
      begin
        win_ff <= 1'b0;
        xld_ff <= ~(xseen_ff | x_rise);                        // RULE25
      end
    end
  end

  // source handover and divide by two
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sw_ff   <= PCC_SW_RUN;
      src_ff  <= 1'b0;
      xcnt_ff <= 3'd0;
      vcnt_ff <= 3'd0;
      base_ff <= 1'b0;
    end
    else if (!osc_enable_in)
    begin
      sw_ff   <= PCC_SW_RUN;
      src_ff  <= 1'b0;
      base_ff <= 1'b0;                                         // RULE23
    end
    else
    begin
      unique case (sw_ff)
        PCC_SW_RUN:
        begin
          if (bcs_ff != src_ff)
          begin
            sw_ff   <= PCC_SW_HOLD;
            xcnt_ff <= 3'd0;
            vcnt_ff <= 3'd0;
          end
          else if (src_ff ? v_rise : x_rise)
            base_ff <= ~base_ff;                               // RULE1
        end
        PCC_SW_HOLD:
        begin
          // output held static until the crystal and, while the pll is on, the vco have ticked
          if (x_rise && xcnt_ff != HAND_CNT)
            xcnt_ff <= xcnt_ff + 3'd1;
          if (v_rise && vcnt_ff != HAND_CNT)
            vcnt_ff <= vcnt_ff + 3'd1;
          if (xcnt_ff == HAND_CNT && (vcnt_ff == HAND_CNT || !pll_en_ff))
          begin
            sw_ff   <= PCC_SW_RUN;                             // RULE12
            src_ff  <= bcs_ff;
          end
        end
      endcase
    end
  end

  // output flops
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      xclk_ff   <= 1'b0;
      irq_ff    <= 1'b0;
      pll_en_ff <= 1'b0;
    end
    else
    begin
      xclk_ff   <= sync2_ff[SX] & osc_enable_in;               // RULE23
      irq_ff    <= flag_ff & ie_ff & auto_ff & osc_enable_in;  // RULE8
      pll_en_ff <= on_ff & osc_enable_in;                      // RULE21
    end
  end

  assign s_axi_awready       = awready_ff;
  assign s_axi_wready        = wready_ff;
  assign s_axi_bvalid        = bvalid_ff;
  assign s_axi_bresp         = bresp_ff;
  assign s_axi_arready       = arready_ff;
  assign s_axi_rvalid        = rvalid_ff;
  assign s_axi_rresp         = rresp_ff;
  assign s_axi_rdata         = rdata_ff;
  assign xtal_clock_out      = xclk_ff;
  assign base_clock_out      = base_ff;
  assign pll_irq             = irq_ff;
  assign pll_enable_out      = pll_en_ff;
  assign auto_bw_out         = auto_ff;
  assign manual_tracking_out = trk_man_ff;
  assign multiplier_out      = prog_ff[7:4];
  assign vco_range_out       = prog_ff[3:0];

endmodule // pcc_top
`default_nettype wire

/* core/pcc_pkg.sv */
// constants and types of the pll clock select control block
// Contract
// (RULE1) base_clock_out is a 50% clock: xtal_clock or vco_clock divided by two.
// (RULE2) control register index 0x1c: enable b7, flag b6, pll on b5, select b4; 3:0 read one.
// (RULE3) reset sets pll_on_a and clears enable, flag and clock select.
// (RULE4) interrupt enable ignores writes and reads zero while automatic mode is off.
// (RULE5) interrupt flag sets on every lock indicator change, enabled or not; the code sets it only in automatic mode with osc_enable_in high.
// (RULE6) interrupt flag reads zero while automatic mode is off.
// (RULE7) any read of the control register clears the flag; flag is not writable.
// (RULE8) pll_irq is high while flag and enable are both set.
// (RULE9) while clock select is set, pll_on_a stays one and ignores clearing.
// (RULE10) pll off or zero vco range forces clock select to zero, read-only.
// (RULE11) software selects vco clock from pll off in two separate writes.
// (RULE12) handover waits up to three xtal and three vco edges, output held static.
// (RULE13) reset and stop both clear clock select, returning to crystal source.
// (RULE14) while pll_on_a is one the programming register ignores writes.
// (RULE15) bandwidth register index 0x1d: auto b7, lock b6, tracking b5, loss b4; resets zero.
// (RULE16) lock reads as synced lock in automatic mode, zero otherwise, never writable.
// (RULE17) tracking_mode is status in automatic mode, writable loop mode in manual mode.
// (RULE18) manual tracking value is kept through automatic mode and restored afterwards.
// (RULE19) software clears tracking_mode before turning the pll on in manual mode.
// (RULE20) writing one to loss flag starts a four times N check window.
// (RULE21) oscillator and pll run only while osc_enable_in is high.
// (RULE22) with clock select clear, loss detection idles and loss flag reads zero.
// (RULE23) osc_enable_in low holds xtal_clock, base_clock_out and pll_irq low.
// (RULE24) lock and acquisition inputs pass two-flop synchronisers before use.
// (RULE25) a crystal edge inside the window clears the loss flag, else it stays set.
package pcc_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] PCC_CTRL_IDX    = 8'h1c;
  localparam logic [7:0] PCC_BW_IDX      = 8'h1d;
  localparam logic [7:0] PCC_PROG_IDX    = 8'h1e;

  // control register fields
  localparam int unsigned PCC_CTRL_IE_BIT   = 7;
  localparam int unsigned PCC_CTRL_FLAG_BIT = 6;
  localparam int unsigned PCC_CTRL_ON_BIT   = 5;
  localparam int unsigned PCC_CTRL_SEL_BIT  = 4;
  localparam logic [3:0]  PCC_CTRL_UNIMP    = 4'hf;
  localparam logic [7:0]  PCC_CTRL_RESET    = 8'h2f;

  // bandwidth register fields
  localparam int unsigned PCC_BW_AUTO_BIT   = 7;
  localparam int unsigned PCC_BW_LOCK_BIT   = 6;
  localparam int unsigned PCC_BW_TRK_BIT    = 5;
  localparam int unsigned PCC_BW_XLD_BIT    = 4;
  localparam logic [7:0]  PCC_BW_RESET      = 8'h00;

  // programming register: multiplier in 7:4, vco range in 3:0
  localparam logic [7:0]  PCC_PROG_RESET    = 8'h66;

  // timing counts
  localparam int unsigned PCC_HANDOVER_EDGES = 3;
  localparam int unsigned PCC_LOSS_MULT      = 4;

  // bus answers
  localparam logic [1:0]  PCC_RESP_OKAY     = 2'b00;
  localparam logic [1:0]  PCC_RESP_SLVERR   = 2'b10;

  typedef enum logic [1:0] {
    PCC_SEL_CTRL = 2'b00,
    PCC_SEL_BW   = 2'b01,
    PCC_SEL_PROG = 2'b11,
    PCC_SEL_NONE = 2'b10
  } pcc_sel_t;

  typedef enum logic {
    PCC_SW_RUN  = 1'b0,
    PCC_SW_HOLD = 1'b1
  } pcc_sw_t;

endpackage

/* verif/pcc_props.sv */
// assertion checker for the pll clock select control block
`timescale 1ns/1ns
`default_nettype none
module pcc_props
  import pcc_pkg::*;
#(
  parameter int unsigned ADDR_W = 12
)
(
  // clock and reset
  input wire logic              aclk,
  input wire logic              aresetn,
  // register bus
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic              s_axi_rvalid,
  input wire logic [31:0]       s_axi_rdata,
  // clock side
  input wire logic              osc_enable_in,
  input wire logic              xtal_clock_in,
  input wire logic              xtal_clock_out,
  input wire logic              base_clock_out,
  input wire logic              pll_irq,
  input wire logic              pll_enable_out,
  input wire logic              auto_bw_out,
  input wire logic [3:0]        multiplier_out,
  input wire logic [3:0]        vco_range_out
);
  localparam logic [ADDR_W-1:0] A_CTRL = ADDR_W'({PCC_CTRL_IDX, 2'b00});
  localparam logic [ADDR_W-1:0] A_BW   = ADDR_W'({PCC_BW_IDX, 2'b00});

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_stop_low: assert property (
    !osc_enable_in |=> !pll_irq && !base_clock_out && !xtal_clock_out && !pll_enable_out)
    else $error("outputs not held low in stop mode");
  a_xtal_delay: assert property (
    osc_enable_in [*4] |-> xtal_clock_out == $past(xtal_clock_in, 3))
    else $error("crystal output does not follow its source");
  a_irq_auto_osc: assert property (
    pll_irq |-> $past(auto_bw_out) && $past(osc_enable_in))
    else $error("interrupt raised outside automatic mode");
  a_pll_en_osc: assert property (
    pll_enable_out |-> $past(osc_enable_in))
    else $error("pll enabled without oscillator enable");
  a_prog_hold: assert property (
    pll_enable_out && $past(pll_enable_out) |-> $stable(multiplier_out) && $stable(vco_range_out))
    else $error("programming fields changed while pll on");
  a_base_steady: assert property (
    $changed(base_clock_out) && osc_enable_in |=> $stable(base_clock_out))
    else $error("base clock toggled on consecutive cycles");
  a_wr_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid)
    else $error("write answer late or ready not dropped");
  a_ctrl_read: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == A_CTRL
    |=> s_axi_rvalid && s_axi_rdata[3:0] == 4'hf && ($past(auto_bw_out) || s_axi_rdata[7:6] == 2'b00))
    else $error("control read value wrong");
  a_bw_read: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == A_BW
    |=> s_axi_rdata[3:0] == 4'h0 && s_axi_rdata[7] == $past(auto_bw_out)
        && ($past(auto_bw_out) || s_axi_rdata[6] == 1'b0))
    else $error("bandwidth read value wrong");
endmodule // pcc_props

bind pcc_top pcc_props #(.ADDR_W(ADDR_W)) i_pcc_props (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
  .osc_enable_in(osc_enable_in), .xtal_clock_in(xtal_clock_in),
  .xtal_clock_out(xtal_clock_out), .base_clock_out(base_clock_out), .pll_irq(pll_irq),
  .pll_enable_out(pll_enable_out), .auto_bw_out(auto_bw_out),
  .multiplier_out(multiplier_out), .vco_range_out(vco_range_out)
);
`default_nettype wire

/* verif/pcc_loop_model.sv */
// behavioural model of the crystal and analog loop around the block
`timescale 1ns/1ns
`default_nettype none
module pcc_loop_model
(
  // clock
  input  wire logic aclk,
  // controls
  input  wire logic osc_enable_in,
  input  wire logic pll_enable_out,
  input  wire logic lock_req,
  input  wire logic xtal_alive,
  // loop outputs
  output logic      xtal_clock_in,
  output logic      vco_clock_in,
  output logic      lock_in,
  output logic      acq_in
);
  logic [2:0] xc = 3'h0;
  logic [1:0] vc = 2'h0;
  logic       xq = 1'b0;
  logic       vq = 1'b0;
  logic       lq = 1'b0;
  assign xtal_clock_in = xq;
  assign vco_clock_in = vq;
  assign lock_in = lq;
  assign acq_in = lq;
  // crystal half period 5 cycles, vco half period 3 cycles
  always @(posedge aclk)
  begin
    xc <= (xc == 3'h4) ? 3'h0 : xc + 3'h1;
    if (xc == 3'h4 && osc_enable_in && xtal_alive) xq <= ~xq;
    vc <= (vc == 2'h2) ? 2'h0 : vc + 2'h1;
    if (!pll_enable_out) vq <= 1'b0;
    else if (vc == 2'h2) vq <= ~vq;
    lq <= lock_req && pll_enable_out;
  end
endmodule // pcc_loop_model
`default_nettype wire

/* verif/testbench.sv */
// self-checking bench for the pll clock select control block
`timescale 1ns/1ns
`default_nettype none
module testbench
  import pcc_pkg::*;
;
  localparam logic [11:0] A_CTRL = {2'b00, PCC_CTRL_IDX, 2'b00};
  localparam logic [11:0] A_BW   = {2'b00, PCC_BW_IDX, 2'b00};
  localparam logic [11:0] A_PROG = {2'b00, PCC_PROG_IDX, 2'b00};
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        osc_en = 1'b1, lock_req = 1'b0, xtal_alive = 1'b1;
  logic        awready, wready, bvalid, arready, rvalid, auto_bw, man_trk;
  logic        xtal_in, vco_in, lock_in, acq_in, xtal_out, base_out, irq, pll_en;
  logic [1:0]  bresp, rresp, rs;
  logic [31:0] rdata;
  logic [3:0]  mult, vrange;
  logic [7:0]  rv;
  int          mismatches = 0, compares = 0, cyc = 0;

  always #20 aclk = ~aclk;

  pcc_top i_pcc_top (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .osc_enable_in(osc_en), .xtal_clock_out(xtal_out), .base_clock_out(base_out),
    .pll_irq(irq), .xtal_clock_in(xtal_in), .vco_clock_in(vco_in), .lock_in(lock_in),
    .acq_in(acq_in), .pll_enable_out(pll_en), .auto_bw_out(auto_bw),
    .manual_tracking_out(man_trk), .multiplier_out(mult), .vco_range_out(vrange)
  );
  pcc_loop_model i_pcc_loop_model (
    .aclk(aclk), .osc_enable_in(osc_en), .pll_enable_out(pll_en), .lock_req(lock_req),
    .xtal_alive(xtal_alive), .xtal_clock_in(xtal_in), .vco_clock_in(vco_in),
    .lock_in(lock_in), .acq_in(acq_in)
  );

  task automatic chk_val(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_bit(input string n, input logic e, input logic g);
    chk_val(n, {7'h0, e}, {7'h0, g});
  endtask
  // both channels offered together, each released when taken
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while ((awvalid && !awready) || (wvalid && !wready));
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
    rs = bresp;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
    rv = rdata[7:0];
    rs = rresp;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e, input string n);
    rd(a);
    chk_val(n, e, rv);
  endtask
  task automatic wc(input logic [11:0] a, input logic [7:0] d, input logic [7:0] e);
    wr(a, d);
    rd_chk(a, e, "readback");
  endtask
  // two full halves of the base clock after a settling gap
  task automatic half_per(input logic [7:0] e);
    logic b;
    int n;
    repeat (60) @(posedge aclk);
    for (int k = 0; k < 3; k++)
    begin
      b = base_out;
      n = 0;
      do
      begin
        @(posedge aclk);
        n++;
      end
      while (base_out === b);
      if (k > 0) chk_val("base half period", e, 8'(n));
    end
  endtask
  task automatic results();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      mismatches++;
      results();
    end
  end

  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(A_CTRL, PCC_CTRL_RESET, "ctrl");
    rd_chk(A_BW, PCC_BW_RESET, "bw");
    rd_chk(A_PROG, PCC_PROG_RESET, "prog");
    wr(12'h07c, 8'hff);
    chk_val("bresp", {6'h0, PCC_RESP_SLVERR}, {6'h0, rs});
    rd(12'h07c);
    chk_val("rresp", {6'h0, PCC_RESP_SLVERR}, {6'h0, rs});
    $display("reset test done");
    wc(A_CTRL, 8'hff, 8'h3f);
    half_per(8'd6);
    wc(A_CTRL, 8'h0f, 8'h2f);
    half_per(8'd10);
    wc(A_CTRL, 8'h00, 8'h0f);
    wc(A_CTRL, 8'h30, 8'h2f);
    wc(A_CTRL, 8'h30, 8'h3f);
    wc(A_CTRL, 8'h20, 8'h2f);
    $display("select test done");
    wc(A_PROG, 8'h00, 8'h66);
    wc(A_CTRL, 8'h00, 8'h0f);
    wc(A_PROG, 8'h20, 8'h20);
    chk_val("mult", 8'h02, {4'h0, mult});
    wc(A_CTRL, 8'h20, 8'h2f);
    wc(A_CTRL, 8'h30, 8'h2f);
    wc(A_CTRL, 8'h00, 8'h0f);
    wc(A_PROG, 8'h26, 8'h26);
    wc(A_CTRL, 8'h20, 8'h2f);
    $display("program test done");
    wc(A_BW, 8'h20, 8'h20);
    chk_bit("manual tracking", 1'b1, man_trk);
    wc(A_BW, 8'ha0, 8'h80);
    wr(A_BW, 8'h80);
    wc(A_BW, 8'h00, 8'h20);
    wc(A_BW, 8'h00, 8'h00);
    $display("tracking test done");
    wr(A_BW, 8'h80);
    wc(A_CTRL, 8'ha0, 8'haf);
    lock_req <= 1'b1;
    repeat (10) @(posedge aclk);
    chk_bit("irq", 1'b1, irq);
    rd_chk(A_BW, 8'he0, "bw");
    rd_chk(A_CTRL, 8'hef, "ctrl");
    rd_chk(A_CTRL, 8'haf, "ctrl");
    chk_bit("irq", 1'b0, irq);
    wc(A_CTRL, 8'he0, 8'haf);
    lock_req <= 1'b0;
    repeat (10) @(posedge aclk);
    wr(A_BW, 8'h00);
    rd_chk(A_CTRL, 8'h2f, "ctrl");
    chk_bit("irq", 1'b0, irq);
    $display("lock test done");
    wc(A_BW, 8'h10, 8'h00);
    wc(A_CTRL, 8'h30, 8'h3f);
    wr(A_BW, 8'h10);
    repeat (100) @(posedge aclk);
    rd_chk(A_BW, 8'h00, "loss");
    xtal_alive <= 1'b0;
    wr(A_BW, 8'h10);
    repeat (100) @(posedge aclk);
    rd_chk(A_BW, 8'h10, "loss");
    xtal_alive <= 1'b1;
    $display("loss test done");
    osc_en <= 1'b0;
    repeat (3) @(posedge aclk);
    chk_bit("base", 1'b0, base_out);
    chk_bit("xtal", 1'b0, xtal_out);
    chk_bit("pll enable", 1'b0, pll_en);
    osc_en <= 1'b1;
    rd_chk(A_CTRL, 8'h2f, "ctrl");
    $display("stop test done");
    results();
  end
endmodule // testbench
`default_nettype wire
